// [design/aecb_top.sv]
// Purpose: Auto exposure configuration bank with statistics and loop, AXI4-Lite slave.
// Assumes: Pixel stream and frame marker come from logic on CLK.
// Notes:   Unmapped accesses answer SLVERR; reads of them return zero.
`timescale 1ns/1ns
module aecb_top
  import aecb_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RESETN,
  input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic [2:0]          S_AXI_AWPROT,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic [2:0]          S_AXI_ARPROT,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  input  wire logic                PIX_VALID,
  input  wire logic [9:0]          PIX_DATA,
  input  wire logic [1:0]          PIX_COLOR,
  input  wire logic                FRAME_END,
  output logic [15:0]              EXPOSURE,
  output logic [1:0]               GAIN_STAGE1,
  output logic [1:0]               GAIN_STAGE2,
  output logic                     LOOP_LOCKED
);
  import aecb_pkg::*;

  // Register storage
  logic [4:0]        ctrl_reg;
  logic [15:0]       target_reg;
  logic [9:0]        weight_reg [4];

  // Write channel state
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;

  // Read channel state
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // Statistics state
  logic [1:0]        sub_cnt_reg [4];
  logic [9:0]        avg_reg;

  // Filter outputs
  logic [15:0]       exposure_q;
  logic [1:0]        gain1_q;
  logic [1:0]        gain2_q;
  logic              locked_q;

  // Control decode
  wire loop_run   = ctrl_reg[CTRL_RUN];
  wire restart    = ctrl_reg[CTRL_RESTART];
  wire freeze     = ctrl_reg[CTRL_FREEZE];
  wire subsample  = ctrl_reg[CTRL_SUBSAMP];
  wire amp_pri    = ctrl_reg[CTRL_AMP_PRI];

  // Write address decode
  wire aw_take    = S_AXI_AWVALID && awready_reg;
  wire w_take     = S_AXI_WVALID && wready_reg;
  wire do_write   = aw_have_reg && w_have_reg && !bvalid_reg;
  wire [5:0] w_idx = aw_addr_reg[7:2];
  wire w_ctrl     = (w_idx == IDX_CTRL);
  wire w_target   = (w_idx == IDX_TARGET);
  wire w_weight   = (w_idx >= IDX_RED) && (w_idx <= IDX_BLUE);
  wire w_status   = (w_idx == IDX_STATUS);
  wire w_mapped   = w_ctrl || w_target || w_weight || w_status;
  wire [1:0] w_sel = 2'(w_idx - IDX_RED);
  wire [15:0] w_lane_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // Merged values honour byte strobes on the low two lanes
  wire [15:0] ctrl_merged   = ({11'h000, ctrl_reg} & ~w_lane_mask) | (w_data_reg[15:0] & w_lane_mask);
  wire [15:0] target_merged = (target_reg & ~w_lane_mask) | (w_data_reg[15:0] & w_lane_mask);
  wire [15:0] weight_merged = ({6'h00, weight_reg[w_sel]} & ~w_lane_mask) | (w_data_reg[15:0] & w_lane_mask);

  // Read address decode
  wire ar_take    = S_AXI_ARVALID && arready_reg;
  wire [5:0] r_idx = S_AXI_ARADDR[7:2];
  wire r_weight   = (r_idx >= IDX_RED) && (r_idx <= IDX_BLUE);
  wire [1:0] r_sel = 2'(r_idx - IDX_RED);
  wire [31:0] status_word = {19'h00000, locked_q, 2'h0, avg_reg};
  wire r_mapped   = (r_idx == IDX_CTRL) || (r_idx == IDX_TARGET) || r_weight || (r_idx == IDX_STATUS);
  wire [31:0] r_word = (r_idx == IDX_CTRL)   ? {27'h0000000, ctrl_reg} :
                       (r_idx == IDX_TARGET) ? {16'h0000, target_reg} :
                       r_weight              ? {22'h000000, weight_reg[r_sel]} :
                       (r_idx == IDX_STATUS) ? status_word : 32'h0000_0000;

  wire [9:0]  pix_weight = weight_reg[PIX_COLOR];
  wire [19:0] pix_prod   = PIX_DATA * pix_weight;
  wire [12:0] pix_scaled = pix_prod[19:WEIGHT_FRAC];
  wire [9:0]  pix_sat    = (pix_scaled > 13'h03ff) ? 10'h3ff : pix_scaled[9:0];

  // every fourth pixel of the channel when subsampling
  wire pix_keep   = !subsample || (sub_cnt_reg[PIX_COLOR] == 2'h0);
  wire stats_en   = loop_run && !freeze && !restart;
  wire pix_use    = PIX_VALID && stats_en && pix_keep;

  // Running average of the weighted samples
  wire signed [11:0] avg_diff = $signed({2'b00, pix_sat}) - $signed({2'b00, avg_reg});
  wire signed [11:0] avg_adj  = avg_diff >>> AVG_SHIFT;
  wire [11:0] avg_sum  = 12'({2'b00, avg_reg} + avg_adj);
  wire [9:0]  avg_next = (avg_adj == 12'sh000) ? (avg_diff[11] ? avg_reg - 10'h001 :
                         (avg_diff != 12'sh000) ? avg_reg + 10'h001 : avg_reg) : avg_sum[9:0];

  // loop steps once a frame only while running and not held
  wire filter_step = FRAME_END && stats_en;

  // Write channel: address and data accepted in either order
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
    end else begin
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
        awready_reg <= 1'b0;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
        wready_reg <= 1'b0;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Register updates; status is read-only and ignores writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg      <= RST_CTRL;
      target_reg    <= RST_TARGET;
      for (int i = 0; i < 4; i++) begin
        weight_reg[i] <= RST_WEIGHT;
      end
    end else if (do_write) begin
      if (w_ctrl) begin
        ctrl_reg <= ctrl_merged[4:0];
      end
      if (w_target) begin
        target_reg <= target_merged;
      end
      if (w_weight) begin
        weight_reg[w_sel] <= weight_merged[9:0];
      end
    end
  end

  // Read channel
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= r_word;
      rresp_reg   <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // Statistics: subsample counters and running average
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      avg_reg <= 10'h000;
      for (int i = 0; i < 4; i++) begin
        sub_cnt_reg[i] <= 2'h0;
      end
    end else if (restart) begin
      avg_reg <= 10'h000;
      for (int i = 0; i < 4; i++) begin
        sub_cnt_reg[i] <= 2'h0;
      end
    end else if (PIX_VALID && stats_en) begin
      sub_cnt_reg[PIX_COLOR] <= sub_cnt_reg[PIX_COLOR] + 2'h1;
      if (pix_use) begin
        avg_reg <= avg_next;
      end
    end
  end

  aecb_filter u_filter (
    .clk          (CLK),
    .resetn       (RESETN),
    .step         (filter_step),
    .restart      (restart),
    .amp_pri      (amp_pri),
    .target       (target_reg[9:0]),
    .average      (avg_reg),
    .exposure_reg (exposure_q),
    .gain1_reg    (gain1_q),
    .gain2_reg    (gain2_q),
    .locked_reg   (locked_q)
  );

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY  = wready_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign EXPOSURE      = exposure_q;
  assign GAIN_STAGE1   = gain1_q;
  assign GAIN_STAGE2   = gain2_q;
  assign LOOP_LOCKED   = locked_q;
endmodule : aecb_top

// [common/aecb_pkg.sv]
// What this block does
// - Control bit 0 runs the exposure loop, bit 1 reinitialises the loop filter, bit 2 holds filter and gains.
// - Control bit 3 low feeds every pixel of a channel into the statistics, high only every fourth one.
// - Control bit 4 high gives the first amplifier stage gain priority over the second, low the reverse; resets high.
// - Red, first green, second green and blue samples are scaled by 10-bit 3.7 unsigned weights resetting to 128.
// - A read-only status word shows the 10-bit measured average and, in bit 12, whether the filter has settled.
//
// Purpose: Shared constants for the auto exposure configuration bank.
// Assumes: AXI4-Lite, 32-bit data, register index times four is the byte address.
// Notes:   Loop tuning figures are plain defaults.
package aecb_pkg;
  localparam int ADDR_W = 8;

  // Register indices
  localparam logic [5:0] IDX_CTRL      = 6'h00;
  localparam logic [5:0] IDX_TARGET    = 6'h01;
  localparam logic [5:0] IDX_RED       = 6'h02;
  localparam logic [5:0] IDX_GREEN1    = 6'h03;
  localparam logic [5:0] IDX_GREEN2    = 6'h04;
  localparam logic [5:0] IDX_BLUE      = 6'h05;
  localparam logic [5:0] IDX_STATUS    = 6'h1A;

  // Control and status bit positions
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_FREEZE  = 2;
  localparam int CTRL_SUBSAMP = 3;
  localparam int CTRL_AMP_PRI = 4;
  localparam int STAT_LOCKED  = 12;

  // Reset values
  localparam logic [4:0]  RST_CTRL   = 5'h10;
  localparam logic [15:0] RST_TARGET = 16'h60b8;
  localparam logic [9:0]  RST_WEIGHT = 10'h080;

  // Weight format: fraction bits
  localparam int WEIGHT_FRAC = 7;

  // Loop behaviour
  localparam int          AVG_SHIFT    = 4;
  localparam logic [9:0]  LOCK_BAND    = 10'h008;
  localparam logic [15:0] EXP_MIN      = 16'h0001;
  localparam logic [15:0] EXP_MAX      = 16'h03ff;
  localparam logic [15:0] EXP_INIT     = 16'h0001;
  localparam logic [1:0]  GAIN1_MAX    = 2'h1;
  localparam logic [1:0]  GAIN2_MAX    = 2'h3;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : aecb_pkg

// [design/aecb_filter.sv]
// Purpose: Frame-rate exposure and gain loop filter.
// Assumes: One step pulse per frame, already gated by run and freeze.
// Notes:   Brightening uses exposure first, then gain; darkening undoes gain first.
`timescale 1ns/1ns
module aecb_filter
  import aecb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        step,
  input  wire logic        restart,
  input  wire logic        amp_pri,
  input  wire logic [9:0]  target,
  input  wire logic [9:0]  average,
  output logic      [15:0] exposure_reg,
  output logic      [1:0]  gain1_reg,
  output logic      [1:0]  gain2_reg,
  output logic             locked_reg
);
  logic signed [10:0] err;
  logic        [9:0]  err_abs;
  logic               settled;
  logic               brighten;
  logic               darken;
  logic        [16:0] exp_up;
  logic        [16:0] exp_dn;
  logic        [15:0] exp_step;
  logic               exp_top;
  logic               exp_bottom;
  logic               g1_up;
  logic               g2_up;
  logic               g1_dn;
  logic               g2_dn;

  assign err        = $signed({1'b0, target}) - $signed({1'b0, average});
  assign err_abs    = err[10] ? 10'(-err) : err[9:0];
  assign settled    = (err_abs <= LOCK_BAND);
  assign brighten   = step && !settled && !err[10];
  assign darken     = step && !settled && err[10];
  // Step grows with the error so large misses close in few frames
  assign exp_step   = {8'h00, err_abs[9:2]} + 16'h0001;
  assign exp_up     = {1'b0, exposure_reg} + {1'b0, exp_step};
  assign exp_dn     = {1'b0, exposure_reg} - {1'b0, exp_step};
  assign exp_top    = (exposure_reg >= EXP_MAX);
  assign exp_bottom = (exposure_reg <= EXP_MIN);

  // priority stage rises first and falls last
  assign g1_up = brighten && exp_top && (amp_pri ? (gain1_reg < GAIN1_MAX)
                                                 : (gain2_reg == GAIN2_MAX) && (gain1_reg < GAIN1_MAX));
  assign g2_up = brighten && exp_top && (amp_pri ? (gain1_reg == GAIN1_MAX) && (gain2_reg < GAIN2_MAX)
                                                 : (gain2_reg < GAIN2_MAX));
  assign g2_dn = darken && (amp_pri ? (gain2_reg != 2'h0) : (gain1_reg == 2'h0) && (gain2_reg != 2'h0));
  assign g1_dn = darken && (amp_pri ? (gain2_reg == 2'h0) && (gain1_reg != 2'h0) : (gain1_reg != 2'h0));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exposure_reg <= EXP_INIT;
      gain1_reg    <= 2'h0;
      gain2_reg    <= 2'h0;
      locked_reg   <= 1'b0;
    end else if (restart) begin
      exposure_reg <= EXP_INIT;
      gain1_reg    <= 2'h0;
      gain2_reg    <= 2'h0;
      locked_reg   <= 1'b0;
    end else begin
      if (step) begin
        locked_reg <= settled;
      end
      if (brighten && !exp_top) begin
        exposure_reg <= (exp_up > {1'b0, EXP_MAX}) ? EXP_MAX : exp_up[15:0];
      end else if (darken && (gain1_reg == 2'h0) && (gain2_reg == 2'h0) && !exp_bottom) begin
        exposure_reg <= (exp_dn[16] || (exp_dn < {1'b0, EXP_MIN})) ? EXP_MIN : exp_dn[15:0];
      end
      if (g1_up) begin
        gain1_reg <= gain1_reg + 2'h1;
      end else if (g1_dn) begin
        gain1_reg <= gain1_reg - 2'h1;
      end
      if (g2_up) begin
        gain2_reg <= gain2_reg + 2'h1;
      end else if (g2_dn) begin
        gain2_reg <= gain2_reg - 2'h1;
      end
    end
  end
endmodule : aecb_filter

// [verification/aecb_monitor.sv]
// Purpose: Port-level checks for the exposure config bank.
// Assumes: Only top-level ports are visible.
// Notes:   Restart is not visible, so loop checks allow a return to reset values.
`timescale 1ns/1ns
module aecb_monitor
  import aecb_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RESETN,
  input wire logic              S_AXI_AWVALID,
  input wire logic              S_AXI_AWREADY,
  input wire logic              S_AXI_WREADY,
  input wire logic [1:0]        S_AXI_BRESP,
  input wire logic              S_AXI_BVALID,
  input wire logic              S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [31:0]       S_AXI_RDATA,
  input wire logic [1:0]        S_AXI_RRESP,
  input wire logic              S_AXI_RVALID,
  input wire logic              S_AXI_RREADY,
  input wire logic              FRAME_END,
  input wire logic [15:0]       EXPOSURE,
  input wire logic [1:0]        GAIN_STAGE1,
  input wire logic [1:0]        GAIN_STAGE2,
  input wire logic              LOOP_LOCKED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

  aw_take_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY) else $error("aw ready stayed high");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response not held");
  b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write channel not freed");
  ar_answer_a: assert property (ar_take |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read not answered");
  r_done_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read channel not freed");
  rd_unmapped_a: assert property (ar_take && S_AXI_ARADDR[7:2] > IDX_BLUE && S_AXI_ARADDR[7:2] != IDX_STATUS
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000) else $error("unmapped read not refused");
  status_word_a: assert property (ar_take && S_AXI_ARADDR[7:2] == IDX_STATUS |=> S_AXI_RDATA[31:13] == 0
    && S_AXI_RDATA[11:10] == 0 && S_AXI_RDATA[12] == $past(LOOP_LOCKED)) else $error("status word wrong");
  loop_range_a: assert property (EXPOSURE >= EXP_MIN && EXPOSURE <= EXP_MAX
    && GAIN_STAGE1 <= GAIN1_MAX && GAIN_STAGE2 <= GAIN2_MAX) else $error("loop output out of range");
  exp_step_a: assert property ($changed(EXPOSURE) |-> $past(FRAME_END) || EXPOSURE == EXP_INIT)
    else $error("exposure moved without a frame");
  gain_step_a: assert property ($changed({GAIN_STAGE1, GAIN_STAGE2}) |-> $past(FRAME_END)
    || {GAIN_STAGE1, GAIN_STAGE2} == 4'h0) else $error("gain moved without a frame");

  cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == RESP_SLVERR);
  cover property (ar_take ##1 S_AXI_RVALID && S_AXI_RREADY);
  cover property (GAIN_STAGE1 != 2'h0);
  cover property (GAIN_STAGE2 != 2'h0);
endmodule : aecb_monitor

bind aecb_top aecb_monitor u_mon (.CLK(CLK), .RESETN(RESETN), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .FRAME_END(FRAME_END), .EXPOSURE(EXPOSURE), .GAIN_STAGE1(GAIN_STAGE1), .GAIN_STAGE2(GAIN_STAGE2),
  .LOOP_LOCKED(LOOP_LOCKED));

// [verification/tb_aecb_top.sv]
// Purpose: Register, statistics and loop tests for the exposure config bank.
// Assumes: Ready is looked at on the falling edge before the edge that takes the item.
// Notes:   Expected averages come from a local filter step model.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_aecb_top;
  import aecb_pkg::*;
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pix_valid, frame_end, locked;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp, pix_color, gain1, gain2;
  logic [9:0]        pix_data;
  logic [15:0]       exposure;
  int                mismatches, checks, avg;

  aecb_top u_dut (.CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PIX_VALID(pix_valid), .PIX_DATA(pix_data), .PIX_COLOR(pix_color),
    .FRAME_END(frame_end), .EXPOSURE(exposure), .GAIN_STAGE1(gain1), .GAIN_STAGE2(gain2),
    .LOOP_LOCKED(locked));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done();
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rs;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        `CHK("bresp", er, rs)
        return;
      end
    end
    mismatches++;
    test_done();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (r) begin
        rready <= 1'b0;
        `CHK("rdata", ed, d)
        `CHK("rresp", er, rs)
        return;
      end
    end
    mismatches++;
    test_done();
  endtask : axi_rd

  task automatic pix(input logic [1:0] c, input logic [9:0] d);
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_color <= c;
    pix_data <= d;
    @(posedge clk);
    pix_valid <= 1'b0;
  endtask : pix

  task automatic frame();
    @(posedge clk);
    frame_end <= 1'b1;
    @(posedge clk);
    frame_end <= 1'b0;
    @(negedge clk);
  endtask : frame

  // Filter step moves at least one count toward the sample
  function automatic int fstep(int a, int s);
    int dl;
    dl = (s - a) >>> 4;
    if (dl == 0 && s != a) dl = (s > a) ? 1 : -1;
    return a + dl;
  endfunction : fstep

  // Drive exposure to its ceiling, then one more frame moves a gain stage
  task automatic climb();
    for (int i = 0; i < 12 && exposure !== EXP_MAX; i++) frame();
    `CHK("exposure", EXP_MAX, exposure)
    frame();
  endtask : climb

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, pix_valid, frame_end} = '0;
    {awaddr, araddr, wdata, pix_data, pix_color} = '0;
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    axi_rd(8'h00, 32'h0000_0010, RESP_OKAY);
    axi_rd(8'h04, 32'h0000_60b8, RESP_OKAY);
    for (int i = 2; i < 6; i++) axi_rd(8'(i * 4), 32'h0000_0080, RESP_OKAY);
    axi_rd(8'h68, 32'h0000_0000, RESP_OKAY);
    axi_rd(8'h18, 32'h0000_0000, RESP_SLVERR);
    axi_wr(8'h18, 32'h0000_1234, RESP_SLVERR);
    axi_wr(8'h68, 32'h0000_1fff, RESP_OKAY);
    axi_wr(8'h0c, 32'h0000_0040, RESP_OKAY);
    axi_rd(8'h0c, 32'h0000_0040, RESP_OKAY);
    axi_wr(8'h00, 32'h0000_0003, RESP_OKAY);
    axi_wr(8'h00, 32'h0000_0001, RESP_OKAY);
    avg = fstep(0, 800);
    pix(2'd0, 10'd800);
    axi_rd(8'h68, 32'(avg), RESP_OKAY);
    avg = fstep(avg, 400);
    pix(2'd1, 10'd800);
    axi_rd(8'h68, 32'(avg), RESP_OKAY);
    frame();
    `CHK("exposure", 16'(1 + ((184 - avg) >> 2) + 1), exposure)
    axi_wr(8'h00, 32'h0000_0005, RESP_OKAY);
    pix(2'd0, 10'd100);
    frame();
    `CHK("exposure", 16'(1 + ((184 - avg) >> 2) + 1), exposure)
    axi_wr(8'h00, 32'h0000_0000, RESP_OKAY);
    pix(2'd0, 10'd100);
    axi_rd(8'h68, 32'(avg), RESP_OKAY);
    axi_wr(8'h00, 32'h0000_001b, RESP_OKAY);
    axi_wr(8'h00, 32'h0000_0019, RESP_OKAY);
    `CHK("exposure", EXP_INIT, exposure)
    avg = fstep(0, 800);
    repeat (4) pix(2'd0, 10'd800);
    axi_rd(8'h68, 32'(avg), RESP_OKAY);
    avg = fstep(avg, 800);
    pix(2'd0, 10'd800);
    axi_rd(8'h68, 32'(avg), RESP_OKAY);
    axi_wr(8'h04, 32'h0000_03ff, RESP_OKAY);
    climb();
    `CHK("gains", 4'h4, {gain1, gain2})
    axi_wr(8'h00, 32'h0000_0003, RESP_OKAY);
    // Restart reaches the gains only at the edge that ends the write
    @(negedge clk);
    `CHK("gains", 4'h0, {gain1, gain2})
    axi_wr(8'h00, 32'h0000_0001, RESP_OKAY);
    climb();
    `CHK("gains", 4'h1, {gain1, gain2})
    // Darkening undoes gain before exposure, then a met target locks the loop
    axi_wr(8'h04, 32'h0000_0000, RESP_OKAY);
    avg = fstep(0, 800);
    pix(2'd0, 10'd800);
    frame();
    `CHK("gains", 4'h0, {gain1, gain2})
    `CHK("exposure", EXP_MAX, exposure)
    frame();
    `CHK("exposure", 16'(EXP_MAX - ((avg >> 2) + 1)), exposure)
    `CHK("locked", 1'b0, locked)
    axi_wr(8'h04, 32'(avg), RESP_OKAY);
    frame();
    `CHK("locked", 1'b1, locked)
    axi_rd(8'h68, 32'h0000_1000 | 32'(avg), RESP_OKAY);
    test_done();
  end
endmodule : tb_aecb_top
